//--- design/rxpc_pkg.sv
// constants and types for the receive path power control block
//
// What this block does
// - both low-noise amp bits set: modem controls
// - mixer state decoded from its bit pair
// - mixer decoded off: mixer disabled
// - baseband amp pair decoded; off disables amp
// - mixer buffer state decoded from its pair
// - buffer decoded off: buffer kept disabled
package rxpc_pkg;
    localparam int         ADDR_W          = 8;
    localparam int         DATA_W          = 8;
    localparam int         NUM_CIRCUITS    = 4;
    // register offsets
    localparam logic [7:0] OFFSET_POWER_DOWN = 8'h00;
    localparam logic [7:0] OFFSET_POWER_UP   = 8'h01;
    localparam logic [7:0] OFFSET_STATUS     = 8'h02;
    // field positions, same bit in each register
    localparam int         POS_LNA         = 7;
    localparam int         POS_RX_MIXER    = 6;
    localparam int         POS_BB_AMP      = 5;
    localparam int         POS_MIX_BUFFER  = 4;
    localparam int         POS_LOW         = 4;
    // reset values
    localparam logic [3:0] RESET_OFF_CTL   = 4'h0;
    localparam logic [3:0] RESET_ON_CTL    = 4'h0;
    // decoded state of one circuit
    typedef enum logic [1:0] {
        RXPC_FORCED_ON,
        RXPC_FORCED_OFF,
        RXPC_MODEM
    } rxpc_state_t;
endpackage

//--- design/rxpc_power_if.sv
// bundle between the register bank and the power decoder
`timescale 1ns/1ps
interface rxpc_power_if;
    import rxpc_pkg::*;
    logic [3:0] offCtl;   // power-down bits, lna at 3 .. buffer at 0
    logic [3:0] onCtl;    // companion power-up bits
    logic [3:0] modemOn;  // modem request per circuit
    logic [3:0] enable;   // decoded enable per circuit
    modport bank    (output offCtl, output onCtl, output modemOn, input enable);
    modport decoder (input offCtl, input onCtl, input modemOn, output enable);
endinterface

//--- design/rxpc_power_decode.sv
// decodes each circuit's bit pair into an enable
`timescale 1ns/1ps
module rxpc_power_decode
    import rxpc_pkg::*;
(
    rxpc_power_if.decoder pwr
);
    // three-way decode of one pair
    function automatic rxpc_state_t decodePair(input logic offBit, input logic onBit);
        if (!offBit)
            return RXPC_FORCED_ON;
        else if (!onBit)
            return RXPC_FORCED_OFF;
        else
            return RXPC_MODEM;
    endfunction

    // enable per circuit; forced off draws no current
    for (genvar i = 0; i < NUM_CIRCUITS; i++) begin : g_circuit
        rxpc_state_t state;
        assign state = decodePair(pwr.offCtl[i], pwr.onCtl[i]);
        assign pwr.enable[i] = (state == RXPC_FORCED_ON)
                             | ((state == RXPC_MODEM) & pwr.modemOn[i]);
    end
endmodule // rxpc_power_decode

//--- design/rxpc_rx_path_power.sv
// register bank and registered enables for the receive path analog circuits
`timescale 1ns/1ps
module rxpc_rx_path_power
    import rxpc_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              arst_n,
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic [DATA_W-1:0] writeData,
    input  wire logic              writeStrobe,
    input  wire logic              readStrobe,
    output logic      [DATA_W-1:0] readData,
    input  wire logic              modemLnaOn,
    input  wire logic              modemMixerOn,
    input  wire logic              modemAmpOn,
    input  wire logic              modemBufferOn,
    output logic                   lnaEnable,
    output logic                   mixerEnable,
    output logic                   ampEnable,
    output logic                   bufferEnable
);
    rxpc_power_if pwr ();

    logic [3:0] offCtl;
    logic [3:0] onCtl;

    // address decode and read selection
    wire        hitOff    = (address == OFFSET_POWER_DOWN);
    wire        hitOn     = (address == OFFSET_POWER_UP);
    wire        hitStatus = (address == OFFSET_STATUS);
    wire [3:0]  fieldIn   = writeData[POS_LNA:POS_MIX_BUFFER];
    wire [3:0]  statusBits = {lnaEnable, mixerEnable, ampEnable, bufferEnable};
    wire [3:0]  readField = hitOff    ? offCtl :
                            hitOn     ? onCtl :
                            hitStatus ? statusBits : 4'h0;
    wire [DATA_W-1:0] next_readData = readStrobe ? {readField, 4'h0} : 8'h00;

    // bundle towards the decoder
    assign pwr.offCtl  = offCtl;
    assign pwr.onCtl   = onCtl;
    assign pwr.modemOn = {modemLnaOn, modemMixerOn, modemAmpOn, modemBufferOn};

    rxpc_power_decode u_decode (
        .pwr (pwr.decoder)
    );

    // power-down field register
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            offCtl <= RESET_OFF_CTL;
        else if (writeStrobe && hitOff)
            offCtl <= fieldIn;
    end

    // power-up field register
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            onCtl <= RESET_ON_CTL;
        else if (writeStrobe && hitOn)
            onCtl <= fieldIn;
    end

    // read data, valid only in the cycle after the strobe
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            readData <= 8'h00;
        else
            readData <= next_readData;
    end

    // registered enables towards the analog circuits
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lnaEnable    <= 1'b1;
            mixerEnable  <= 1'b1;
            ampEnable    <= 1'b1;
            bufferEnable <= 1'b1;
        end
        else
        begin
            lnaEnable    <= pwr.enable[3];
            mixerEnable  <= pwr.enable[2];
            ampEnable    <= pwr.enable[1];
            bufferEnable <= pwr.enable[0];
        end
    end

    // checks on the decoded enables and on idle read data
    lna_modem_follow_a: assert property (@(posedge clock) disable iff (!arst_n)
        offCtl[3] && onCtl[3] |=> lnaEnable == $past(modemLnaOn))
        else $error("lna enable does not follow modem under automatic control");

    mixer_forced_off_a: assert property (@(posedge clock) disable iff (!arst_n)
        offCtl[2] && !onCtl[2] |=> !mixerEnable)
        else $error("mixer enabled while forced off");

    mixer_modem_follow_a: assert property (@(posedge clock) disable iff (!arst_n)
        offCtl[2] && onCtl[2] && !modemMixerOn |=> !mixerEnable)
        else $error("mixer on though modem requests off");

    amp_forced_off_a: assert property (@(posedge clock) disable iff (!arst_n)
        offCtl[1] && !onCtl[1] |=> !ampEnable)
        else $error("baseband amp enabled while forced off");

    buffer_decode_a: assert property (@(posedge clock) disable iff (!arst_n)
        offCtl[0] && onCtl[0] |=> bufferEnable == $past(modemBufferOn))
        else $error("buffer enable does not follow modem");

    buffer_held_off_a: assert property (@(posedge clock) disable iff (!arst_n)
        writeStrobe && hitOff && fieldIn[0] && !onCtl[0] && !(writeStrobe && hitOn)
        |=> ##1 !bufferEnable)
        else $error("buffer not disabled two cycles after forced off write");

    forced_on_a: assert property (@(posedge clock) disable iff (!arst_n)
        offCtl == 4'h0 |=> lnaEnable && mixerEnable && ampEnable && bufferEnable)
        else $error("circuit off although power-down bit clear");

    read_timing_a: assert property (@(posedge clock) disable iff (!arst_n)
        !readStrobe |=> readData == 8'h00)
        else $error("read data present without a read strobe");

    // further checks on decode, register writes and read data
    // lna forced off by its pair
    lna_forced_off_a: assert property (@(posedge clock) disable iff (!arst_n)
        offCtl[3] && !onCtl[3] |=> !lnaEnable)
        else $error("lna enabled while forced off");

    // lna forced on with its power-down bit clear
    lna_forced_on_a: assert property (@(posedge clock) disable iff (!arst_n)
        !offCtl[3] |=> lnaEnable)
        else $error("lna off although power-down bit clear");

    // lna on when the modem asks under automatic control
    lna_modem_on_a: assert property (@(posedge clock) disable iff (!arst_n)
        offCtl[3] && onCtl[3] && modemLnaOn |=> lnaEnable)
        else $error("lna off though modem requests on");

    // mixer forced on with its power-down bit clear
    mixer_forced_on_a: assert property (@(posedge clock) disable iff (!arst_n)
        !offCtl[2] |=> mixerEnable)
        else $error("mixer off although power-down bit clear");

    // mixer on when the modem asks under automatic control
    mixer_modem_on_a: assert property (@(posedge clock) disable iff (!arst_n)
        offCtl[2] && onCtl[2] && modemMixerOn |=> mixerEnable)
        else $error("mixer off though modem requests on");

    // baseband amp forced on with its power-down bit clear
    amp_forced_on_a: assert property (@(posedge clock) disable iff (!arst_n)
        !offCtl[1] |=> ampEnable)
        else $error("baseband amp off although power-down bit clear");

    // baseband amp follows the modem under automatic control
    amp_modem_follow_a: assert property (@(posedge clock) disable iff (!arst_n)
        offCtl[1] && onCtl[1] |=> ampEnable == $past(modemAmpOn))
        else $error("baseband amp does not follow modem");

    // baseband amp on when the modem asks
    amp_modem_on_a: assert property (@(posedge clock) disable iff (!arst_n)
        offCtl[1] && onCtl[1] && modemAmpOn |=> ampEnable)
        else $error("baseband amp off though modem requests on");

    // buffer forced on with its power-down bit clear
    buffer_forced_on_a: assert property (@(posedge clock) disable iff (!arst_n)
        !offCtl[0] |=> bufferEnable)
        else $error("buffer off although power-down bit clear");

    // buffer forced off by its pair
    buffer_forced_off_a: assert property (@(posedge clock) disable iff (!arst_n)
        offCtl[0] && !onCtl[0] |=> !bufferEnable)
        else $error("buffer enabled while forced off");

    // power-down write lands in the register
    off_write_lands_a: assert property (@(posedge clock) disable iff (!arst_n)
        writeStrobe && hitOff |=> offCtl == $past(fieldIn))
        else $error("power-down write did not land");

    // power-up write lands in the register
    on_write_lands_a: assert property (@(posedge clock) disable iff (!arst_n)
        writeStrobe && hitOn |=> onCtl == $past(fieldIn))
        else $error("power-up write did not land");

    // power-down register holds without its write
    off_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
        !(writeStrobe && hitOff) |=> $stable(offCtl))
        else $error("power-down register changed without a write");

    // power-up register holds without its write
    on_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
        !(writeStrobe && hitOn) |=> $stable(onCtl))
        else $error("power-up register changed without a write");

    // status place is read only
    status_ro_a: assert property (@(posedge clock) disable iff (!arst_n)
        writeStrobe && hitStatus |=> $stable(offCtl) && $stable(onCtl))
        else $error("status write changed a register");

    // unmapped writes are ignored
    unmapped_write_a: assert property (@(posedge clock) disable iff (!arst_n)
        writeStrobe && !hitOff && !hitOn |=> $stable(offCtl) && $stable(onCtl))
        else $error("unmapped write changed a register");

    // read of the power-down register
    read_off_data_a: assert property (@(posedge clock) disable iff (!arst_n)
        readStrobe && hitOff |=> readData == {$past(offCtl), 4'h0})
        else $error("wrong power-down read data");

    // read of the power-up register
    read_on_data_a: assert property (@(posedge clock) disable iff (!arst_n)
        readStrobe && hitOn |=> readData == {$past(onCtl), 4'h0})
        else $error("wrong power-up read data");

    // read of the enable status
    read_status_data_a: assert property (@(posedge clock) disable iff (!arst_n)
        readStrobe && hitStatus |=> readData == {$past(statusBits), 4'h0})
        else $error("wrong status read data");

    // read of an unmapped place returns zero
    read_unmapped_a: assert property (@(posedge clock) disable iff (!arst_n)
        readStrobe && !hitOff && !hitOn && !hitStatus |=> readData == 8'h00)
        else $error("unmapped read returned data");
endmodule // rxpc_rx_path_power

//--- testbench/rxpc_rx_path_power_tb.sv
// self-checking bench for the receive path power register bank
`timescale 1ns/1ps
module rxpc_rx_path_power_tb
    import rxpc_pkg::*;
;
    logic       clock = 1'b0;
    logic       arst_n = 1'b0;
    logic [7:0] address = 8'h00;
    logic [7:0] writeData = 8'h00;
    logic       writeStrobe = 1'b0;
    logic       readStrobe = 1'b0;
    logic [3:0] modem = 4'h0;
    logic [7:0] readData;
    logic [3:0] enable;
    logic [7:0] d;
    logic [3:0] e;
    int         fails = 0;
    int         samples_checked = 0;

    // 20 MHz clock
    always #25 clock = ~clock;

    rxpc_rx_path_power DUT (.clock(clock), .arst_n(arst_n), .address(address),
        .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
        .readData(readData), .modemLnaOn(modem[3]), .modemMixerOn(modem[2]),
        .modemAmpOn(modem[1]), .modemBufferOn(modem[0]), .lnaEnable(enable[3]),
        .mixerEnable(enable[2]), .ampEnable(enable[1]), .bufferEnable(enable[0]));

    // compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one-cycle register write
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        address <= a;
        writeData <= v;
        writeStrobe <= 1'b1;
        @(posedge clock);
        writeStrobe <= 1'b0;
    endtask

    // one-cycle read, data taken in the following cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clock);
        address <= a;
        readStrobe <= 1'b1;
        @(posedge clock);
        readStrobe <= 1'b0;
        #1 v = readData;
    endtask

    // verdict and end of run
    task automatic end_of_test;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // watchdog against a hang
    initial
    begin
        #1000000;
        fails++;
        $display("BAD %0t watchdog expired", $time);
        end_of_test;
    end

    // test sequence
    initial
    begin
        repeat (3) @(posedge clock);
        arst_n <= 1'b1;
        #1 chk({enable, 4'h0}, 8'hF0);
        rd(OFFSET_POWER_DOWN, d);
        chk(d, 8'h00);
        rd(OFFSET_POWER_UP, d);
        chk(d, 8'h00);
        $display("reset test done");
        // every bit pair, modem request set to the xor of the pair's two bits
        for (int i = 0; i < 16; i++)
            for (int j = 0; j < 16; j++)
            begin
                @(posedge clock);
                modem <= i[3:0] ^ j[3:0];
                e = ~i[3:0] | (j[3:0] & (i[3:0] ^ j[3:0]));
                wr(OFFSET_POWER_DOWN, {i[3:0], 4'hF});
                wr(OFFSET_POWER_UP, {j[3:0], 4'hF});
                repeat (2) @(posedge clock);
                #1 chk({enable, 4'h0}, {e, 4'h0});
                rd(OFFSET_POWER_DOWN, d);
                chk(d, {i[3:0], 4'h0});
                rd(OFFSET_POWER_UP, d);
                chk(d, {j[3:0], 4'h0});
                rd(OFFSET_STATUS, d);
                chk(d, {e, 4'h0});
            end
        $display("decode test done");
        // modem control follows the request one cycle later
        wr(OFFSET_POWER_DOWN, 8'hF0);
        wr(OFFSET_POWER_UP, 8'hF0);
        for (int k = 0; k < 16; k++)
        begin
            @(posedge clock);
            modem <= k[3:0];
            @(posedge clock);
            #1 chk({enable, 4'h0}, {k[3:0], 4'h0});
        end
        $display("modem test done");
        // read-only and unmapped places leave the power-down register alone
        wr(OFFSET_STATUS, 8'h00);
        wr(8'hFF, 8'h00);
        rd(OFFSET_POWER_DOWN, d);
        chk(d, 8'hF0);
        rd(8'h7F, d);
        chk(d, 8'h00);
        @(posedge clock);
        #1 chk(readData, 8'h00);
        $display("access test done");
        end_of_test;
    end
endmodule // rxpc_rx_path_power_tb
